// ### bench/lsc_mem_model.sv
// Behavioural data memory on the far side of the memory port.
`timescale 1ns/1ps
module lsc_mem_model (
  // Clock and pacing.
  input  wire logic                  aclk,
  input  wire logic                  slow,
  // Memory port.
  input  wire logic                  mem_valid,
  input  wire lsc_pkg::lsc_mem_req_t mem_req,
  output logic                       mem_ready,
  output logic [31:0]                mem_rdata,
  // Last accepted beat.
  output logic [31:0]                last_addr,
  output logic [31:0]                last_wdata
);
  import lsc_pkg::*;
  logic [31:0] mem [0:63];
  logic [1:0]  wait_q = 2'h0;
  logic [5:0]  idx;
  initial for (int i = 0; i < 64; i++) mem[i] = 32'h0;
  assign idx = mem_req.addr[7:2];
  assign mem_ready = mem_valid && (!slow || wait_q == 2'h3);
  // Outside an accepted beat the data shows the inverse, so stale data cannot pass.
  assign mem_rdata = mem_ready ? mem[idx] : ~mem[idx];
  always @(posedge aclk) begin
    wait_q <= (mem_valid && !mem_ready) ? wait_q + 2'h1 : 2'h0;
    if (mem_ready) begin
      last_addr <= mem_req.addr;
      last_wdata <= mem_req.wdata;
      for (int b = 0; b < 4; b++)
        if (mem_req.we && mem_req.be[b]) mem[idx][8*b +: 8] <= mem_req.wdata[8*b +: 8];
    end
  end
endmodule

// ### bench/tb.sv
// Self-checking testbench of the load/store context unit.
`timescale 1ns/1ps
`include "lsc_map.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  import lsc_pkg::*;
  logic         aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
  logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]  wdata = 32'h0, rd, rdata, mem_rdata, last_addr, last_wdata;
  logic [1:0]   bresp, rresp, rr;
  logic         awready, wready, bvalid, arready, rvalid, mem_valid, mem_ready, alignment_trap;
  lsc_mem_req_t mem_req;
  int           errors = 0, n_checks = 0, n_trap = 0;
  always #4 aclk = ~aclk;
  always @(posedge aclk) if (alignment_trap === 1'b1) n_trap++;
  lsc_core #(.ADDR_W(8)) DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .mem_valid(mem_valid), .mem_req(mem_req),
    .mem_ready(mem_ready), .mem_rdata(mem_rdata), .alignment_trap(alignment_trap));
  lsc_mem_model mem_i (.aclk(aclk), .slow(slow), .mem_valid(mem_valid), .mem_req(mem_req),
    .mem_ready(mem_ready), .mem_rdata(mem_rdata), .last_addr(last_addr), .last_wdata(last_wdata));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (i == 40) begin errors++; tally_and_finish(); end
    `CHK("bresp", er, bresp)
  endtask
  task automatic axr(input logic [7:0] a);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
    if (i == 40) begin errors++; tally_and_finish(); end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    axr(a);
    `CHK(n, e, rd)
  endtask
  function automatic logic [31:0] cw(lsc_op_t op, lsc_mode_t m, logic [1:0] sz, logic sg, logic [3:0] ar,
                                     logic [3:0] dr, logic [4:0] ps, logic [4:0] wd);
    return {1'b1, wd, 1'b0, ps, dr, ar, 1'b0, sg, sz, 1'b0, m, op};
  endfunction
  task automatic run(input logic [31:0] c, input logic [31:0] o);
    int i;
    axw(`LSC_OFF_OPND, o, `LSC_RESP_OK);
    axw(`LSC_OFF_CTRL, c, `LSC_RESP_OK);
    for (i = 0; i < 40; i++) begin
      axr(`LSC_OFF_STAT);
      if (rd[0] === 1'b0) break;
    end
    if (i == 40) begin errors++; tally_and_finish(); end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rchk("stat", `LSC_OFF_STAT, 32'h0);
    axr(8'h20);
    `CHK("rresp", `LSC_RESP_ERR, rr)
    axw(8'h20, 32'h1, `LSC_RESP_ERR);
  endtask
  task automatic t_store();
    slow <= 1'b1;
    axw(8'h84, 32'h12348f00, `LSC_RESP_OK);
    run(cw(op_store, am_absolute, 2'h2, 1'b0, 4'h0, 4'h1, 5'h0, 5'h0), 32'h40);
    `CHK("addr", 32'h40, last_addr)
    run(cw(op_store, am_absolute, 2'h2, 1'b0, 4'h0, 4'h1, 5'h0, 5'h0), 32'hfffe0044);
    `CHK("abs", 32'h20044, last_addr)
    slow <= 1'b0;
  endtask
  task automatic t_ext();
    logic [31:0] e [4] = '{32'hffffff8f, 32'h0000008f, 32'hffff8f00, 32'h00008f00};
    for (int k = 0; k < 4; k++) begin
      run(cw(op_load, am_absolute, 2'(k / 2), 1'(~k), 4'h0, 4'h4, 5'h0, 5'h0), k < 2 ? 32'h41 : 32'h40);
      rchk("ldext", 8'h90, e[k]);
    end
  endtask
  task automatic t_incr();
    axw(8'hd4, 32'h100, `LSC_RESP_OK);
    run(cw(op_store, am_pre_inc, 2'h2, 1'b0, 4'h5, 4'h1, 5'h0, 5'h0), 32'h3fc);
    `CHK("pre", 32'hfc, last_addr)
    rchk("a5pre", 8'hd4, 32'hfc);
    run(cw(op_store, am_post_inc, 2'h2, 1'b0, 4'h5, 4'h1, 5'h0, 5'h0), 32'h3fc);
    `CHK("post", 32'hfc, last_addr)
    rchk("a5post", 8'hd4, 32'hf8);
    run(cw(op_store, am_short, 2'h2, 1'b0, 4'h5, 4'h1, 5'h0, 5'h0), 32'hfffffbf8);
    `CHK("short", 32'hf0, last_addr)
    run(cw(op_store, am_long, 2'h2, 1'b0, 4'h5, 4'h1, 5'h0, 5'h0), 32'h0001fff0);
    `CHK("long", 32'he8, last_addr)
  endtask
  task automatic t_bits();
    run(cw(op_insert_mask, am_absolute, 2'h0, 1'b0, 4'h0, 4'h2, 5'h7, 5'h4), 32'hb);
    rchk("value", 8'h88, 32'h580);
    rchk("mask", 8'h8c, 32'h780);
    run(cw(op_load_modify_store, am_absolute, 2'h2, 1'b0, 4'h0, 4'h2, 5'h0, 5'h0), 32'h40);
    `CHK("ldmst", 32'h12348d80, last_wdata)
    run(cw(store_single_bit_op, am_absolute, 2'h2, 1'b0, 4'h0, 4'h0, 5'h3, 5'h0), 32'h4041);
    `CHK("stbaddr", 32'h10000040, last_addr)
    `CHK("stbdata", 32'h12348580, last_wdata)
    axw(8'hd8, 32'h40, `LSC_RESP_OK);
    run(cw(op_load_bit, am_absolute, 2'h0, 1'b0, 4'h6, 4'h7, 5'h0, 5'h0), 32'h2b);
    `CHK("bitaddr", 32'h44, last_addr)
    rchk("bit", 8'h9c, 32'h1);
    run(cw(scaled_bit_offset_add, am_absolute, 2'h2, 1'b0, 4'h6, 4'h8, 5'h0, 5'h0), 32'h2b);
    rchk("scaled", 8'he0, 32'h44);
  endtask
  task automatic t_ctx();
    run(cw(store_upper_context_op, am_absolute, 2'h2, 1'b0, 4'h0, 4'h0, 5'h0, 5'h0), 32'h44);
    rchk("aln", `LSC_OFF_STAT, 32'h2);
    `CHK("trap", 1, n_trap)
    run(cw(store_upper_context_op, am_absolute, 2'h2, 1'b0, 4'h0, 4'h0, 5'h0, 5'h0), 32'h80);
    `CHK("ctxend", 32'hbc, last_addr)
    `CHK("trapok", 1, n_trap)
    axw(`LSC_OFF_FCX, 32'h100, `LSC_RESP_OK);
    run(cw(begin_interrupt_routine_op, am_absolute, 2'h2, 1'b0, 4'h0, 4'h0, 5'h0, 5'h0), 32'h5a);
    rchk("icr", `LSC_OFF_ICR, 32'h5a01);
    `CHK("save", 32'h13c, last_addr)
    axw(8'hec, 32'h77, `LSC_RESP_OK);
    axw(8'h9c, 32'h0, `LSC_RESP_OK);
    run(cw(load_lower_context_op, am_absolute, 2'h2, 1'b0, 4'h0, 4'h0, 5'h0, 5'h0), 32'h100);
    rchk("lld7", 8'h9c, 32'h1);
    rchk("llra", 8'hec, 32'h77);
    rchk("llpcxi", `LSC_OFF_PREVIOUS_CONTEXT_INFO, 32'h100);
    run(cw(restore_lower_context_op, am_absolute, 2'h2, 1'b0, 4'h0, 4'h0, 5'h0, 5'h0), 32'h0);
    rchk("rsra", 8'hec, 32'h0);
    rchk("rsfcx", `LSC_OFF_FCX, 32'h100);
    axw(`LSC_OFF_PSW, 32'h33, `LSC_RESP_OK);
    run(cw(load_upper_context_op, am_absolute, 2'h2, 1'b0, 4'h0, 4'h0, 5'h0, 5'h0), 32'h80);
    rchk("lupsw", `LSC_OFF_PSW, 32'h33);
    run(cw(op_call_save, am_absolute, 2'h2, 1'b0, 4'h0, 4'h0, 5'h0, 5'h0), 32'h0);
    axw(`LSC_OFF_PSW, 32'h0, `LSC_RESP_OK);
    run(cw(op_return_restore, am_absolute, 2'h2, 1'b0, 4'h0, 4'h0, 5'h0, 5'h0), 32'h0);
    rchk("retpsw", `LSC_OFF_PSW, 32'h33);
    run(cw(store_lower_context_op, am_absolute, 2'h2, 1'b0, 4'h0, 4'h0, 5'h0, 5'h0), 32'h80);
    `CHK("sld7", 32'h1, last_wdata)
    run(cw(save_lower_context_op, am_absolute, 2'h2, 1'b0, 4'h0, 4'h0, 5'h0, 5'h0), 32'h0);
    rchk("svpcxi", `LSC_OFF_PREVIOUS_CONTEXT_INFO, 32'h100);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_store();
    t_ext();
    t_incr();
    t_bits();
    t_ctx();
    tally_and_finish();
  end
endmodule

// ### hdl/lsc_core.sv
// Load/store and context-transfer unit with an AXI4-Lite register port and a data memory port.
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "lsc_map.svh"
module lsc_core #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite register port.
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [ADDR_W-1:0] araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  // Data memory port.
  output logic                   mem_valid,
  output lsc_pkg::lsc_mem_req_t  mem_req,
  input  wire logic              mem_ready,
  input  wire logic [31:0]       mem_rdata,
  // Trap event.
  output logic                   alignment_trap
);
  import lsc_pkg::*;

  logic [ADDR_W-1:0] aw_q, ar_addr;
  logic [31:0]       w_q, ctrl_q, opnd_q, fcx_q, previous_context_info_q, psw_q, icr_q, ea_q, ctx_addr_q, link_q;
  logic [31:0]       gpr_q [32];
  logic [3:0]        s_q, k_q;
  logic              aw_have_q, w_have_q, bvalid_q, rvalid_q, start_q, aln_q, upper_q, rd_dir_q;
  logic [1:0]        bresp_q;
  logic [31:0]       rdata_q, rd_val, base, sx10, ea_v, ea_sc, rmw_m, rmw_v, im_mask;
  logic              wr_fire, mem_fire, busy, upd;
  lsc_state_t        state_q;
  lsc_op_t           op;
  lsc_mode_t         mode;
  lsc_mem_req_t      req_q;
  logic              mvalid_q, trap_q;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) o[i*8 +: 8] = n[i*8 +: 8];
    end
    return o;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a[1:0] == 2'h0 && (a[`LSC_GPR_BIT] || a[ADDR_W-1:0] <= ADDR_W'(`LSC_OFF_ICR));
  endfunction

  // Gpr index of context word k: D0..D15 are 0..15, A0..A15 are 16..31.
  function automatic logic [4:0] ctx_idx(input logic up, input logic [3:0] k);
    case (k[3:2])
      2'h0:    return up ? 5'(5'h18 + k[1:0]) : 5'(5'h10 + k[1:0]);
      2'h1:    return up ? {3'h2, k[1:0]} : {3'h0, k[1:0]};
      2'h2:    return up ? {3'h7, k[1:0]} : {3'h5, k[1:0]};
      default: return up ? {3'h3, k[1:0]} : {3'h1, k[1:0]};
    endcase
  endfunction

  function automatic logic [31:0] ctx_word(input logic up, input logic [3:0] k);
    if (k == 4'h0) return previous_context_info_q;
    if (k == 4'h1) return up ? psw_q : gpr_q[`LSC_RA_IDX];
    return gpr_q[ctx_idx(up, k)];
  endfunction

  function automatic logic [31:0] ld_ext(input logic [31:0] d, input logic [1:0] a, input logic [1:0] sz,
                                         input logic sg);
    logic [31:0] sh;
    sh = d >> {a, 3'h0};
    if (sz == `LSC_SIZE_B) return sg ? {{24{sh[7]}}, sh[7:0]} : {24'h0, sh[7:0]};
    if (sz == `LSC_SIZE_H) return sg ? {{16{sh[15]}}, sh[15:0]} : {16'h0, sh[15:0]};
    return sh;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Operand decode and address arithmetic.
  assign op       = lsc_op_t'(ctrl_q[`LSC_F_OP]);
  assign mode     = lsc_mode_t'(ctrl_q[`LSC_F_MODE]);
  assign base     = gpr_q[{1'b1, ctrl_q[`LSC_F_AREG]}];
  assign sx10     = {{22{opnd_q[9]}}, opnd_q[9:0]};
  assign upd      = mode == am_pre_inc || mode == am_post_inc;
  assign ea_sc    = (base + {3'h0, opnd_q[31:3]}) & ~32'h3;
  assign im_mask  = ~(32'hffffffff << ctrl_q[`LSC_F_WID]) << ctrl_q[`LSC_F_POS];
  assign wr_fire  = aw_have_q && w_have_q && !bvalid_q;
  assign mem_fire = mvalid_q && mem_ready;
  assign busy     = start_q || state_q != st_idle;

  always_comb begin
    case (mode)
      am_absolute: ea_v = {14'h0, opnd_q[17:0]};
      am_short:    ea_v = base + sx10;
      am_long:     ea_v = base + {{16{opnd_q[15]}}, opnd_q[15:0]};
      am_pre_inc:  ea_v = base + sx10;
      default:     ea_v = base;
    endcase
    if (op == store_single_bit_op) begin
      rmw_m = 32'h1 << {ea_q[1:0], ctrl_q[22:20]};
      rmw_v = ctrl_q[`LSC_F_SGN] ? rmw_m : 32'h0;
    end else begin
      rmw_m = gpr_q[{1'b0, ctrl_q[19:17], 1'b1}];
      rmw_v = gpr_q[{1'b0, ctrl_q[19:17], 1'b0}];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: write and read channels, control and operand registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `LSC_RESP_OK;
      aw_q      <= '0;
      w_q       <= `LSC_RST_WORD;
      s_q       <= 4'h0;
      ctrl_q    <= `LSC_RST_WORD;
      opnd_q    <= `LSC_RST_WORD;
      start_q   <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (awvalid && !aw_have_q) begin
        aw_have_q <= 1'b1;
        aw_q      <= awaddr;
      end
      if (wvalid && !w_have_q) begin
        w_have_q <= 1'b1;
        w_q      <= wdata;
        s_q      <= wstrb;
      end
      if (bvalid_q && bready) bvalid_q <= 1'b0;
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= mapped(aw_q) ? `LSC_RESP_OK : `LSC_RESP_ERR;
        if (!busy && aw_q == ADDR_W'(`LSC_OFF_CTRL)) begin
          ctrl_q  <= merge(ctrl_q, w_q, s_q);
          start_q <= s_q[3] && w_q[`LSC_F_GO];
        end
        if (!busy && aw_q == ADDR_W'(`LSC_OFF_OPND)) opnd_q <= merge(opnd_q, w_q, s_q);
      end
    end
  end

  always_comb begin
    if (ar_addr[`LSC_GPR_BIT]) begin
      rd_val = gpr_q[ar_addr[6:2]];
    end else begin
      case (ar_addr)
        ADDR_W'(`LSC_OFF_CTRL): rd_val = ctrl_q;
        ADDR_W'(`LSC_OFF_OPND): rd_val = opnd_q;
        ADDR_W'(`LSC_OFF_STAT): rd_val = {30'h0, aln_q, busy};
        ADDR_W'(`LSC_OFF_EA):   rd_val = ea_q;
        ADDR_W'(`LSC_OFF_FCX):  rd_val = fcx_q;
        ADDR_W'(`LSC_OFF_PREVIOUS_CONTEXT_INFO): rd_val = previous_context_info_q;
        ADDR_W'(`LSC_OFF_PSW):  rd_val = psw_q;
        ADDR_W'(`LSC_OFF_ICR):  rd_val = icr_q;
        default:                rd_val = `LSC_RST_WORD;
      endcase
    end
  end

  assign ar_addr = araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= `LSC_RST_WORD;
      rresp    <= `LSC_RESP_OK;
    end else if (arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= mapped(araddr) ? rd_val : `LSC_RST_WORD;
      rresp    <= mapped(araddr) ? `LSC_RESP_OK : `LSC_RESP_ERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign awready = !aw_have_q;
  assign wready  = !w_have_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = !rvalid_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Engine: register file, context pointers and memory sequencing.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= st_idle;
      for (int i = 0; i < 32; i++) gpr_q[i] <= `LSC_RST_WORD;
      {fcx_q, previous_context_info_q, psw_q, icr_q} <= '0;
      {ea_q, ctx_addr_q, link_q} <= '0;
      {k_q, upper_q, rd_dir_q, aln_q, trap_q, mvalid_q} <= '0;
      req_q <= '0;
    end else begin
      trap_q <= 1'b0;
      if (wr_fire && aw_q[`LSC_GPR_BIT]) gpr_q[aw_q[6:2]] <= merge(gpr_q[aw_q[6:2]], w_q, s_q);
      if (wr_fire && aw_q == ADDR_W'(`LSC_OFF_FCX))  fcx_q  <= merge(fcx_q, w_q, s_q);
      if (wr_fire && aw_q == ADDR_W'(`LSC_OFF_PREVIOUS_CONTEXT_INFO)) previous_context_info_q <= merge(previous_context_info_q, w_q, s_q);
      if (wr_fire && aw_q == ADDR_W'(`LSC_OFF_PSW))  psw_q  <= merge(psw_q, w_q, s_q);
      if (wr_fire && aw_q == ADDR_W'(`LSC_OFF_ICR))  icr_q  <= merge(icr_q, w_q, s_q);
      if (start_q) aln_q <= 1'b0;
      case (state_q)
        st_idle: if (start_q) begin
          upper_q <= op inside {store_upper_context_op, load_upper_context_op, op_call_save, op_return_restore};
          rd_dir_q <= op inside {load_upper_context_op, load_lower_context_op, restore_lower_context_op,
                                 op_return_restore};
          req_q.we <= 1'b0;
          req_q.be <= 4'hf;
          case (op)
            scaled_bit_offset_add: gpr_q[{1'b1, ctrl_q[`LSC_F_DREG]}] <= ea_sc;
            op_insert_mask: begin
              gpr_q[{1'b0, ctrl_q[19:17], 1'b0}] <= (opnd_q << ctrl_q[`LSC_F_POS]) & im_mask;
              gpr_q[{1'b0, ctrl_q[19:17], 1'b1}] <= im_mask;
            end
            op_load, op_store, op_load_bit, op_load_modify_store, store_single_bit_op: begin
              ea_q <= op == op_load_bit ? ea_sc : ea_v;
              req_q.addr <= {ea_v[31:2], 2'h0};
              if (op == op_load_bit) req_q.addr <= ea_sc;
              if (op == store_single_bit_op) begin
                ea_q       <= {opnd_q[`LSC_STT_SEG], 14'h0, opnd_q[`LSC_STT_LOW]};
                req_q.addr <= {opnd_q[`LSC_STT_SEG], 14'h0, opnd_q[13:2], 2'h0};
              end
              if (op == op_store) begin
                req_q.we    <= 1'b1;
                req_q.be    <= ctrl_q[`LSC_F_SIZE] == `LSC_SIZE_B ? 4'h1 << ea_v[1:0] :
                               ctrl_q[`LSC_F_SIZE] == `LSC_SIZE_H ? (ea_v[1] ? 4'hc : 4'h3) : 4'hf;
                req_q.wdata <= ctrl_q[`LSC_F_SIZE] == `LSC_SIZE_B ? {4{gpr_q[ctrl_q[`LSC_F_DREG]][7:0]}} :
                               ctrl_q[`LSC_F_SIZE] == `LSC_SIZE_H ? {2{gpr_q[ctrl_q[`LSC_F_DREG]][15:0]}} :
                               gpr_q[ctrl_q[`LSC_F_DREG]];
              end
              if (upd && op != op_load_bit && op != store_single_bit_op)
                gpr_q[{1'b1, ctrl_q[`LSC_F_AREG]}] <= base + sx10;
              mvalid_q <= 1'b1;
              state_q  <= op inside {op_load_modify_store, store_single_bit_op} ? st_rmw_rd : st_single;
            end
            store_upper_context_op, load_upper_context_op, store_lower_context_op, load_lower_context_op: begin
              ea_q <= ea_v;
              if (ea_v[`LSC_ALN_BITS] != 6'h0) begin
                trap_q <= 1'b1;
                aln_q  <= 1'b1;
              end else begin
                ctx_addr_q <= ea_v;
                k_q        <= op inside {load_upper_context_op, load_lower_context_op} ?
                              `LSC_CTX_LD_K0 : 4'h0;
                req_q.we   <= !(op inside {load_upper_context_op, load_lower_context_op});
                req_q.addr <= op inside {load_upper_context_op, load_lower_context_op} ? ea_v + 32'h8 : ea_v;
                req_q.wdata <= previous_context_info_q;
                mvalid_q   <= 1'b1;
                state_q    <= st_xfer;
              end
            end
            restore_lower_context_op, op_return_restore: begin
              ctx_addr_q <= previous_context_info_q;
              ea_q       <= previous_context_info_q;
              k_q        <= 4'h0;
              req_q.addr <= previous_context_info_q;
              mvalid_q   <= 1'b1;
              state_q    <= st_xfer;
            end
            default: begin
              ctx_addr_q <= fcx_q;
              ea_q       <= fcx_q;
              req_q.addr <= fcx_q;
              mvalid_q   <= 1'b1;
              state_q    <= st_link;
            end
          endcase
        end
        st_link: if (mem_fire) begin
          link_q      <= mem_rdata;
          k_q         <= 4'h0;
          req_q.we    <= 1'b1;
          req_q.wdata <= previous_context_info_q;
          state_q     <= st_xfer;
        end
        st_xfer: if (mem_fire) begin
          if (rd_dir_q) begin
            if (k_q == 4'h0) link_q <= mem_rdata;
            else if (k_q == 4'h1 && upper_q) psw_q <= mem_rdata;
            else if (k_q == 4'h1) gpr_q[`LSC_RA_IDX] <= mem_rdata;
            else gpr_q[ctx_idx(upper_q, k_q)] <= mem_rdata;
          end
          k_q         <= k_q + 4'h1;
          req_q.addr  <= ctx_addr_q + {26'h0, k_q + 4'h1, 2'h0};
          req_q.wdata <= ctx_word(upper_q, k_q + 4'h1);
          if (k_q == `LSC_CTX_LAST) begin
            mvalid_q <= 1'b0;
            state_q  <= st_idle;
            if (op inside {save_lower_context_op, begin_interrupt_routine_op, op_call_save}) begin
              previous_context_info_q <= ctx_addr_q;
              fcx_q  <= link_q;
            end
            if (op == begin_interrupt_routine_op) begin
              icr_q[`LSC_INTERRUPT_ENABLE_BIT]   <= 1'b1;
              icr_q[`LSC_ICR_CURRENT_CPU_PRIORITY] <= opnd_q[`LSC_NEW_CURRENT_CPU_PRIORITY];
            end
            if (op inside {restore_lower_context_op, op_return_restore}) begin
              req_q.we    <= 1'b1;
              req_q.addr  <= ctx_addr_q;
              req_q.wdata <= fcx_q;
              mvalid_q    <= 1'b1;
              state_q     <= st_free;
            end
          end
        end
        st_free: if (mem_fire) begin
          fcx_q    <= ctx_addr_q;
          previous_context_info_q   <= link_q;
          mvalid_q <= 1'b0;
          state_q  <= st_idle;
        end
        st_rmw_rd: if (mem_fire) begin
          req_q.we    <= 1'b1;
          req_q.wdata <= (mem_rdata & ~rmw_m) | (rmw_v & rmw_m);
          state_q     <= st_rmw_wr;
        end
        st_rmw_wr: if (mem_fire) begin
          mvalid_q <= 1'b0;
          state_q  <= st_idle;
        end
        st_single: if (mem_fire) begin
          mvalid_q <= 1'b0;
          state_q  <= st_idle;
          if (op == op_load_bit) gpr_q[ctrl_q[`LSC_F_DREG]] <= {31'h0, mem_rdata[opnd_q[4:0]]};
          else if (op == op_load)
            gpr_q[ctrl_q[`LSC_F_DREG]] <= ld_ext(mem_rdata, ea_q[1:0], ctrl_q[`LSC_F_SIZE], ctrl_q[`LSC_F_SGN]);
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  assign mem_valid      = mvalid_q;
  assign mem_req        = req_q;
  assign alignment_trap = trap_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_ctx_last;
    state_q == st_xfer && mem_fire && k_q == `LSC_CTX_LAST;
  endsequence
  sequence s_ctx_start;
    start_q && state_q == st_idle && op inside {store_upper_context_op, load_upper_context_op,
                                                store_lower_context_op, load_lower_context_op};
  endsequence

  a_aln_trap_raise: assert property (s_ctx_start and ea_v[5:0] != 6'h0 |=> trap_q && state_q == st_idle)
    else $error("misaligned context access gave no trap");
  a_aln_start_ok: assert property (s_ctx_start and ea_v[5:0] == 6'h0 |=> !trap_q && state_q == st_xfer)
    else $error("aligned context access did not start");
  a_abs_addr: assert property (start_q && state_q == st_idle && op == op_load && mode == am_absolute
    |=> req_q.addr == {14'h0, $past(opnd_q[17:2]), 2'h0}) else $error("absolute address wrong");
  a_post_base: assert property (start_q && state_q == st_idle && op inside {op_load, op_store}
    && mode == am_post_inc |=> req_q.addr[31:2] == $past(base[31:2]) && base == $past(base) + $past(sx10))
    else $error("post-increment wrong");
  a_scaled_align: assert property (start_q && state_q == st_idle && op == scaled_bit_offset_add
    |=> gpr_q[{1'b1, ctrl_q[`LSC_F_DREG]}][1:0] == 2'h0) else $error("scaled address not word aligned");
  a_byte_sext: assert property (state_q == st_single && mem_fire && op == op_load && ctrl_q[`LSC_F_SGN]
    && ctrl_q[`LSC_F_SIZE] == `LSC_SIZE_B |=> gpr_q[ctrl_q[`LSC_F_DREG]][31:8] == {24{gpr_q[ctrl_q[`LSC_F_DREG]][7]}})
    else $error("byte load not sign extended");
  a_rmw_merge: assert property (state_q == st_rmw_rd && mem_fire
    |=> req_q.we && ((req_q.wdata ^ $past(mem_rdata)) & ~$past(rmw_m)) == 32'h0) else $error("unmasked bits changed");
  a_begin_interrupt_routine_op_enable: assert property (s_ctx_last ##0 op == begin_interrupt_routine_op
    |=> icr_q[`LSC_INTERRUPT_ENABLE_BIT] && previous_context_info_q == $past(ctx_addr_q)) else $error("interrupt routine entry incomplete");
  a_upper_load_psw: assert property (state_q == st_xfer && op == load_upper_context_op |=> $stable(psw_q))
    else $error("upper context load changed status word");
  a_ctx_end: assert property (s_ctx_last |=> state_q != st_xfer)
    else $error("context transfer ran past sixteen words");
  a_mem_hold: assert property (mvalid_q && !mem_ready |=> mvalid_q && $stable(req_q))
    else $error("memory request changed before acceptance");
endmodule

// ### inc/lsc_map.svh
// Register offsets, field positions, reset values and counts of the load/store context unit.
`ifndef LSC_MAP_SVH
`define LSC_MAP_SVH
`define LSC_OFF_CTRL  8'h00
`define LSC_OFF_OPND  8'h04
`define LSC_OFF_STAT  8'h08
`define LSC_OFF_EA    8'h0c
`define LSC_OFF_FCX   8'h10
`define LSC_OFF_PREVIOUS_CONTEXT_INFO  8'h14
`define LSC_OFF_PSW   8'h18
`define LSC_OFF_ICR   8'h1c
`define LSC_GPR_BIT   7
`define LSC_F_OP      3:0
`define LSC_F_MODE    6:4
`define LSC_F_SIZE    9:8
`define LSC_F_SGN     10
`define LSC_F_AREG    15:12
`define LSC_F_DREG    19:16
`define LSC_F_POS     24:20
`define LSC_F_WID     30:26
`define LSC_F_GO      31
`define LSC_INTERRUPT_ENABLE_BIT    0
`define LSC_ICR_CURRENT_CPU_PRIORITY  15:8
`define LSC_NEW_CURRENT_CPU_PRIORITY  7:0
`define LSC_STT_SEG   17:14
`define LSC_STT_LOW   13:0
`define LSC_ALN_BITS  5:0
`define LSC_CTX_LAST  4'hf
`define LSC_CTX_LD_K0 4'h2
`define LSC_RA_IDX    5'h1b
`define LSC_SIZE_B    2'h0
`define LSC_SIZE_H    2'h1
`define LSC_RST_WORD  32'h00000000
`define LSC_RESP_OK   2'h0
`define LSC_RESP_ERR  2'h2
`endif

// ### inc/lsc_pkg.sv
// Types of the load/store context unit.
package lsc_pkg;
  typedef enum logic [3:0] {
    op_load, op_store, scaled_bit_offset_add, op_load_bit, store_single_bit_op, op_insert_mask,
    op_load_modify_store, save_lower_context_op, restore_lower_context_op, begin_interrupt_routine_op,
    store_upper_context_op, load_upper_context_op, store_lower_context_op, load_lower_context_op,
    op_call_save, op_return_restore
  } lsc_op_t;
  typedef enum logic [2:0] {am_absolute, am_short, am_long, am_pre_inc, am_post_inc} lsc_mode_t;
  typedef enum logic [2:0] {st_idle, st_link, st_xfer, st_free, st_rmw_rd, st_rmw_wr, st_single} lsc_state_t;
  typedef struct packed {
    logic        we;
    logic [3:0]  be;
    logic [31:0] addr;
    logic [31:0] wdata;
  } lsc_mem_req_t;
endpackage
